// ---- rtl/pcpio_pkg.sv ----
// Purpose : Shared constants and types of the programmed-io target
// Assumes : One Dword of payload per request-stream beat
// Notes   : Region ram indices, trigger words and completion fields live here
package pcpio_pkg;

   // Region geometry: four regions of 2 KB, one word is 4 bytes
   localparam int unsigned REGION_BYTES = 2048;
   localparam int unsigned REGION_COUNT = 4;
   localparam int unsigned REGION_WORDS = REGION_BYTES / 4;
   localparam int unsigned TOTAL_BYTES  = REGION_BYTES * REGION_COUNT;
   localparam int unsigned ADDR_W       = 11;
   localparam int unsigned WIDX_W       = 9;
   localparam int unsigned WIDX_LSB     = 2;
   localparam int unsigned LOW_ADDR_W   = 7;

   // Core stream variant this build matches (64, 128 or 256 in the family)
   localparam int unsigned CORE_STREAM_W = 64;

   // Request kinds: bit 0 marks a write, bit 1 marks I/O space
   localparam logic [1:0] KIND_MEM_RD = 2'h0;
   localparam logic [1:0] KIND_MEM_WR = 2'h1;
   localparam logic [1:0] KIND_IO_RD  = 2'h2;
   localparam logic [1:0] KIND_IO_WR  = 2'h3;

   // Region select codes delivered by the core
   localparam logic [2:0] CODE_MEM32 = 3'h0;
   localparam logic [2:0] CODE_MEM64 = 3'h1;
   localparam logic [2:0] CODE_EROM  = 3'h6;

   // Ram indices of the four regions
   localparam logic [1:0] IO_REGION_RAM            = 2'h0;
   localparam logic [1:0] MEM32_REGION_RAM         = 2'h1;
   localparam logic [1:0] MEM64_REGION_RAM         = 2'h2;
   localparam logic [1:0] EXPANSION_ROM_REGION_RAM = 2'h3;

   // Trigger addresses and data words
   localparam logic [10:0] MRD_TRIG_ADDR = 11'h7AA;
   localparam logic [10:0] IRQ_TRIG_ADDR = 11'h7BB;
   localparam logic [31:0] MRD_TRIG_DATA = 32'hAAAA_BBBB;
   localparam logic [31:0] INTX_DATA     = 32'hCCCC_DDDD;
   localparam logic [31:0] MSI_DATA      = 32'hEEEE_FFFF;
   localparam logic [31:0] MSIX_DATA     = 32'hDEAD_BEEF;

   // Completion fields
   localparam logic [2:0]  STATUS_SC   = 3'h0;
   localparam logic [11:0] CPL_BYTES   = 12'h004;
   localparam logic [10:0] ONE_DWORD   = 11'h001;

   // Request beat: header fields valid on the first beat, data on every beat
   typedef struct packed {
      logic [1:0]  kind;
      logic [2:0]  region_code;
      logic [10:0] dw_count;
      logic [10:0] addr;
      logic [15:0] req_id;
      logic [7:0]  tag;
      logic [2:0]  attr;
      logic [31:0] data;
   } pcpio_req_type;

   // Completion descriptor with optional one-Dword payload
   typedef struct packed {
      logic        has_data;
      logic [2:0]  status;
      logic [11:0] byte_count;
      logic [6:0]  low_addr;
      logic [15:0] req_id;
      logic [7:0]  tag;
      logic [2:0]  attr;
      logic [31:0] data;
   } pcpio_cpl_type;

   // Receive state machine
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_DRAIN  = 4'h2,
      ST_ACCESS = 4'h4,
      ST_CPL    = 4'h8
   } pcpio_state_type;

endpackage

// ---- rtl/pcpio_target.sv ----
// Purpose : Programmed-io completer behind the endpoint core request stream
// Assumes : Core decodes the address and hands the region select code with each request
// Notes   : One request in flight; ready drops while ram and completion are busy
`timescale 1ns/100ps
`default_nettype none
module pcpio_target (
   // Clock, reset and freeze
   input  wire logic                    mclk,
   input  wire logic                    rst,
   input  wire logic                    ce,
   // Request stream from the core
   input  wire logic                    req_valid,
   input  wire logic                    req_last,
   input  wire pcpio_pkg::pcpio_req_type req, // One Dword per beat in every variant
   output logic                         request_stream_ready,
   // Configuration strap
   input  wire logic                    io_region_enable,
   // Completion stream to the core
   output logic                         cpl_valid,
   input  wire logic                    cpl_ready,
   output pcpio_pkg::pcpio_cpl_type     cpl,
   // Event requests, one-cycle pulses
   output logic                         mrd_start,
   output logic                         intx_req,
   output logic                         msi_req,
   output logic                         msix_req
);

   // Region lookup: bit 2 says the request has a home, bits 1:0 pick the ram
   function automatic logic [2:0] region_of(input pcpio_pkg::pcpio_req_type r,
                                            input logic io_en);
      logic [2:0] res;
      res = 3'h0;
      if (r.kind[1]) begin
         res = {io_en, pcpio_pkg::IO_REGION_RAM};
      end else begin
         case (r.region_code)
            pcpio_pkg::CODE_MEM32: res = {1'b1, pcpio_pkg::MEM32_REGION_RAM};
            pcpio_pkg::CODE_MEM64: res = {1'b1, pcpio_pkg::MEM64_REGION_RAM};
            pcpio_pkg::CODE_EROM:  res = {1'b1, pcpio_pkg::EXPANSION_ROM_REGION_RAM};
            default:               res = 3'h0;
         endcase
      end
      return res;
   endfunction

   pcpio_pkg::pcpio_state_type state_reg;
   pcpio_pkg::pcpio_req_type   hdr_reg;
   logic [1:0]                 sel_reg;
   logic                       take;
   logic [2:0]                 sel_now;
   logic                       single_ok;
   logic [8:0]                 widx;
   logic                       hdr_wr;
   logic                       need_cpl;

   // Four separate 2 KB rams, one per region
   logic [31:0] region_ram [0:3][0:511];

   // Ready only while idle or draining; frozen block takes nothing
   assign request_stream_ready = ce &&
      (state_reg == pcpio_pkg::ST_IDLE || state_reg == pcpio_pkg::ST_DRAIN);
   assign take      = req_valid && request_stream_ready;
   assign sel_now   = region_of(req, io_region_enable);
   assign single_ok = req_last && req.dw_count == pcpio_pkg::ONE_DWORD;
   // Only the low address bits index the ram, so wide apertures alias
   assign widx      = hdr_reg.addr[10:2];
   assign hdr_wr    = hdr_reg.kind[0];
   assign need_cpl  = !hdr_wr || hdr_reg.kind == pcpio_pkg::KIND_IO_WR;

   // Receive state machine
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= pcpio_pkg::ST_IDLE;
      end else if (ce) begin
         case (state_reg)
            pcpio_pkg::ST_IDLE: begin
               if (take && !req_last) begin
                  state_reg <= pcpio_pkg::ST_DRAIN;
               end else if (take && single_ok && sel_now[2]) begin
                  state_reg <= pcpio_pkg::ST_ACCESS;
               end
            end
            pcpio_pkg::ST_DRAIN: begin
               if (take && req_last) begin
                  state_reg <= pcpio_pkg::ST_IDLE;
               end
            end
            pcpio_pkg::ST_ACCESS: begin
               state_reg <= need_cpl ? pcpio_pkg::ST_CPL : pcpio_pkg::ST_IDLE;
            end
            pcpio_pkg::ST_CPL: begin
               if (cpl_ready) begin
                  state_reg <= pcpio_pkg::ST_IDLE;
               end
            end
            default: state_reg <= pcpio_pkg::ST_IDLE;
         endcase
      end
   end

   // Header capture on the first beat of every request
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hdr_reg <= '0;
         sel_reg <= 2'h0;
      end else if (ce && take && state_reg == pcpio_pkg::ST_IDLE) begin
         hdr_reg <= req;
         sel_reg <= sel_now[1:0];
      end
   end

   // Ram write; the array carries no reset, as block ram has none
   always_ff @(posedge mclk) begin
      if (ce && state_reg == pcpio_pkg::ST_ACCESS && hdr_wr) begin
         region_ram[sel_reg][widx] <= hdr_reg.data;
      end
   end

   // Completion build and hand-off
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cpl_valid <= 1'b0;
         cpl       <= '0;
      end else if (ce) begin
         if (state_reg == pcpio_pkg::ST_ACCESS && need_cpl) begin
            cpl_valid       <= 1'b1;
            cpl.has_data    <= !hdr_wr;
            cpl.status      <= pcpio_pkg::STATUS_SC;
            cpl.byte_count  <= pcpio_pkg::CPL_BYTES;
            cpl.low_addr    <= hdr_reg.addr[6:0];
            cpl.req_id      <= hdr_reg.req_id;
            cpl.tag         <= hdr_reg.tag;
            cpl.attr        <= hdr_reg.attr;
            cpl.data        <= hdr_wr ? 32'h0000_0000 : region_ram[sel_reg][widx];
         end else if (cpl_valid && cpl_ready) begin
            cpl_valid <= 1'b0;
         end
      end
   end

   // Trigger words: pulses rise on the same edge as the ram write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mrd_start <= 1'b0;
         intx_req  <= 1'b0;
         msi_req   <= 1'b0;
         msix_req  <= 1'b0;
      end else if (ce) begin
         mrd_start <= 1'b0;
         intx_req  <= 1'b0;
         msi_req   <= 1'b0;
         msix_req  <= 1'b0;
         if (state_reg == pcpio_pkg::ST_ACCESS && hdr_wr) begin
            mrd_start <= hdr_reg.addr == pcpio_pkg::MRD_TRIG_ADDR &&
                         hdr_reg.data == pcpio_pkg::MRD_TRIG_DATA;
            intx_req  <= hdr_reg.addr == pcpio_pkg::IRQ_TRIG_ADDR &&
                         hdr_reg.data == pcpio_pkg::INTX_DATA;
            msi_req   <= hdr_reg.addr == pcpio_pkg::IRQ_TRIG_ADDR &&
                         hdr_reg.data == pcpio_pkg::MSI_DATA;
            msix_req  <= hdr_reg.addr == pcpio_pkg::IRQ_TRIG_ADDR &&
                         hdr_reg.data == pcpio_pkg::MSIX_DATA;
         end
      end
   end

   // Checks run only while the block is live
   default clocking @(posedge mclk); endclocking
   default disable iff (rst || !ce);

   sequence take_single_s;
      take && state_reg == pcpio_pkg::ST_IDLE && single_ok && sel_now[2];
   endsequence

   sequence take_wr_s(logic [10:0] a, logic [31:0] d);
      take_single_s ##0 req.kind[0] && req.addr == a && req.data == d;
   endsequence

   busy_not_ready_a: assert property (
      (state_reg == pcpio_pkg::ST_ACCESS || state_reg == pcpio_pkg::ST_CPL)
      |-> !request_stream_ready)
      else $error("ready high while busy");

   // Ready must fall on the very next cycle, before the ram is touched
   access_stall_a: assert property (
      take_single_s |=> !request_stream_ready)
      else $error("request taken during access");

   read_cpl_data_a: assert property (
      take_single_s ##0 !req.kind[0] |-> ##2 cpl_valid && cpl.has_data)
      else $error("read without data completion");

   io_write_cpl_a: assert property (
      take_single_s ##0 req.kind == pcpio_pkg::KIND_IO_WR
      |-> ##2 cpl_valid && !cpl.has_data && cpl.status == pcpio_pkg::STATUS_SC)
      else $error("io write completion wrong");

   write_stored_a: assert property (
      state_reg == pcpio_pkg::ST_ACCESS && hdr_wr
      |=> region_ram[sel_reg][widx] == hdr_reg.data)
      else $error("write data not stored");

   mrd_trigger_a: assert property (
      take_wr_s(pcpio_pkg::MRD_TRIG_ADDR, pcpio_pkg::MRD_TRIG_DATA) |-> ##2 mrd_start)
      else $error("memory read not started");

   intx_trigger_a: assert property (
      take_wr_s(pcpio_pkg::IRQ_TRIG_ADDR, pcpio_pkg::INTX_DATA) |-> ##2 intx_req)
      else $error("legacy interrupt not raised");

   msi_trigger_a: assert property (
      take_wr_s(pcpio_pkg::IRQ_TRIG_ADDR, pcpio_pkg::MSI_DATA) |-> ##2 msi_req)
      else $error("msi not requested");

   msix_trigger_a: assert property (
      take_wr_s(pcpio_pkg::IRQ_TRIG_ADDR, pcpio_pkg::MSIX_DATA) |-> ##2 msix_req)
      else $error("msix not requested");

   long_dropped_a: assert property (
      take && state_reg == pcpio_pkg::ST_IDLE && !req_last
      |=> state_reg == pcpio_pkg::ST_DRAIN && !cpl_valid)
      else $error("long request not drained");

   bad_region_a: assert property (
      take && state_reg == pcpio_pkg::ST_IDLE && req_last && !sel_now[2]
      |=> state_reg == pcpio_pkg::ST_IDLE && !cpl_valid)
      else $error("unsupported region answered");

   cpl_echo_a: assert property (
      cpl_valid |-> cpl.tag == hdr_reg.tag && cpl.req_id == hdr_reg.req_id
                    && cpl.low_addr == hdr_reg.addr[6:0])
      else $error("completion does not echo request");

endmodule
`default_nettype wire

// ---- bench/pcpio_core_model.sv ----
// Purpose : Endpoint core side of the request and completion streams
// Assumes : The caller enters offer just after a falling edge
// Notes   : Completion ready stalls three cycles in four while slow is set
`timescale 1ns/100ps
`default_nettype none
module pcpio_core_model (
   // Request stream
   input  wire logic                mclk,
   input  wire logic                request_stream_ready,
   output logic                     req_valid,
   output logic                     req_last,
   output pcpio_pkg::pcpio_req_type req,
   // Completion stream
   output logic                     cpl_ready
);
   logic       slow = 1'b0;
   logic [1:0] cnt  = 2'h0;

   // Stall pattern moves on the falling edge so ready is settled at sampling
   always @(negedge mclk) begin
      cnt <= cnt + 2'h1;
   end
   assign cpl_ready = !slow || cnt == 2'h3;

   initial begin
      req_valid = 1'b0;
      req_last  = 1'b0;
      req       = '0;
   end

   // One beat, held until taken; released lines are scrambled, not kept
   task automatic offer(input pcpio_pkg::pcpio_req_type r, input logic last,
                        output logic ok);
      int n;
      n = 0;
      req       = r;
      req_last  = last;
      req_valid = 1'b1;
      while (request_stream_ready !== 1'b1 && n < 60) begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
      if (last) begin
         req_valid = 1'b0;
         req       = ~r;
      end
      ok = n < 60;
   endtask
endmodule
`default_nettype wire

// ---- bench/pcpio_target_test.sv ----
// Purpose : Self-checking bench of the programmed-io target
// Assumes : Ram words are only read back after being written
// Notes   : Expected completions and events wait in queues for the monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin fails++; \
   $display("[FAIL] %s exp %h seen %h", nm, e, g); end end
module pcpio_target_test;
   logic                     mclk = 1'b0;
   logic                     rst, ce, io_region_enable;
   logic                     req_valid, req_last, request_stream_ready;
   logic                     cpl_valid, cpl_ready;
   logic                     mrd_start, intx_req, msi_req, msix_req;
   pcpio_pkg::pcpio_req_type req, r;
   pcpio_pkg::pcpio_cpl_type cpl, exp_c;
   pcpio_pkg::pcpio_cpl_type cq[$];
   logic [3:0]               eq[$];
   logic [3:0]               exp_e;
   logic [31:0]              shadow[int];
   logic [31:0]              rnd;
   logic [10:0]              a;
   logic                     ok;
   int                       seed, fails, total_checks;
   logic [2:0]               codes[4];
   logic [42:0]              trig[5];

   pcpio_target u_pcpio_target (.mclk(mclk), .rst(rst), .ce(ce), .req_valid(req_valid),
      .req_last(req_last), .req(req), .request_stream_ready(request_stream_ready),
      .io_region_enable(io_region_enable), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready),
      .cpl(cpl), .mrd_start(mrd_start), .intx_req(intx_req), .msi_req(msi_req),
      .msix_req(msix_req));
   pcpio_core_model u_core (.mclk(mclk), .request_stream_ready(request_stream_ready),
      .req_valid(req_valid), .req_last(req_last), .req(req), .cpl_ready(cpl_ready));

   // 50 MHz clock
   always #10 mclk = ~mclk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Monitor: every taken completion and every event pulse consumes one note
   always @(posedge mclk) begin
      // A frozen block does not see the handshake, so nothing is taken then
      if (!rst && ce === 1'b1 && cpl_valid === 1'b1 && cpl_ready === 1'b1) begin
         if (cq.size() == 0) `CHK("stray cpl", 1'b0, 1'b1)
         else begin
            exp_c = cq.pop_front();
            `CHK("cpl", exp_c, cpl)
         end
      end
      if (!rst && ce === 1'b1 && {mrd_start, intx_req, msi_req, msix_req} !== 4'h0) begin
         if (eq.size() == 0) `CHK("stray event", 1'b0, 1'b1)
         else begin
            // Pop once: the macro names its expected value twice
            exp_e = eq.pop_front();
            `CHK("event", exp_e, {mrd_start, intx_req, msi_req, msix_req})
         end
      end
   end

   // One single-Dword request; the shadow ram and queues predict the outcome
   task automatic xfer(input logic [1:0] k, input logic [2:0] code, input logic [10:0] ad,
                       input logic [31:0] d);
      pcpio_pkg::pcpio_cpl_type c;
      logic                     valid;
      int                       key;
      rnd = $random(seed);
      r = '{kind:k, region_code:code, dw_count:pcpio_pkg::ONE_DWORD, addr:ad,
            req_id:rnd[15:0], tag:rnd[23:16], attr:rnd[26:24], data:d};
      valid = k[1] ? io_region_enable : (code == pcpio_pkg::CODE_MEM32 ||
              code == pcpio_pkg::CODE_MEM64 || code == pcpio_pkg::CODE_EROM);
      key = {k[1] ? 2'h0 : code == pcpio_pkg::CODE_MEM32 ? 2'h1 :
             code == pcpio_pkg::CODE_MEM64 ? 2'h2 : 2'h3, ad[10:2]};
      if (valid && k[0]) begin
         shadow[key] = d;
         if (ad == pcpio_pkg::MRD_TRIG_ADDR && d == pcpio_pkg::MRD_TRIG_DATA) eq.push_back(4'h8);
         if (ad == pcpio_pkg::IRQ_TRIG_ADDR && d == pcpio_pkg::INTX_DATA) eq.push_back(4'h4);
         if (ad == pcpio_pkg::IRQ_TRIG_ADDR && d == pcpio_pkg::MSI_DATA) eq.push_back(4'h2);
         if (ad == pcpio_pkg::IRQ_TRIG_ADDR && d == pcpio_pkg::MSIX_DATA) eq.push_back(4'h1);
      end
      if (valid && (!k[0] || k[1])) begin
         c = '{has_data:!k[0], status:pcpio_pkg::STATUS_SC, byte_count:pcpio_pkg::CPL_BYTES,
               low_addr:ad[6:0], req_id:r.req_id, tag:r.tag, attr:r.attr,
               data:k[0] ? 32'h0000_0000 : shadow[key]};
         cq.push_back(c);
      end
      u_core.offer(r, 1'b1, ok);
      if (!ok) begin
         fails++;
         report_and_stop();
      end
      `CHK("ready busy", !valid, request_stream_ready)
      // Let an edge pass so the next request never re-raises valid in this step
      @(negedge mclk);
   endtask

   initial begin
      seed = 84;
      fails = 0;
      total_checks = 0;
      codes = '{pcpio_pkg::CODE_MEM32, pcpio_pkg::CODE_MEM64, pcpio_pkg::CODE_EROM, 3'h0};
      trig = '{{11'h7AA, 32'hAAAA_BBBB}, {11'h7BB, 32'hCCCC_DDDD}, {11'h7BB, 32'hEEEE_FFFF},
               {11'h7BB, 32'hDEAD_BEEF}, {11'h7BB, 32'hAAAA_BBBB}};
      rst = 1'b1;
      ce = 1'b1;
      io_region_enable = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      // Same address in all four regions, read back with prompt and slow ready
      for (int i = 0; i < 6; i++) begin
         rnd = $random(seed);
         a = rnd[10:0];
         u_core.slow = i[0];
         for (int j = 0; j < 4; j++) xfer({j == 3, 1'b1}, codes[j], a, $random(seed));
         for (int j = 0; j < 4; j++) xfer({j == 3, 1'b0}, codes[j], a, 32'h0000_0000);
      end
      // I/O requests with the region switched off are dropped
      io_region_enable = 1'b0;
      xfer(pcpio_pkg::KIND_IO_WR, 3'h0, a, 32'h1234_5678);
      xfer(pcpio_pkg::KIND_IO_RD, 3'h0, a, 32'h0000_0000);
      io_region_enable = 1'b1;
      xfer(pcpio_pkg::KIND_IO_RD, 3'h0, a, 32'h0000_0000);
      // Unserved region code and a two-Dword write leave the ram untouched
      xfer(pcpio_pkg::KIND_MEM_WR, 3'h2, a, 32'h5555_AAAA);
      xfer(pcpio_pkg::KIND_MEM_RD, 3'h2, a, 32'h0000_0000);
      r = '{pcpio_pkg::KIND_MEM_WR, pcpio_pkg::CODE_MEM32, 11'h002, a, 16'h0000, 8'h00,
            3'h0, 32'h0F0F_0F0F};
      u_core.offer(r, 1'b0, ok);
      `CHK("long beat 1", 1'b1, ok)
      u_core.offer(r, 1'b1, ok);
      `CHK("long beat 2", 1'b1, ok)
      `CHK("drop ready", 1'b1, request_stream_ready)
      @(negedge mclk);
      xfer(pcpio_pkg::KIND_MEM_RD, pcpio_pkg::CODE_MEM32, a, 32'h0000_0000);
      // Trigger words, one near miss, then the last word is read back
      foreach (trig[i]) xfer(pcpio_pkg::KIND_MEM_WR, pcpio_pkg::CODE_MEM64, trig[i][42:32],
                             trig[i][31:0]);
      xfer(pcpio_pkg::KIND_MEM_RD, pcpio_pkg::CODE_MEM64, 11'h7BB, 32'h0000_0000);
      // Freeze while the completion waits: nothing may move or be taken
      ce = 1'b0;
      repeat (3) @(negedge mclk);
      `CHK("frozen ready", 1'b0, request_stream_ready)
      `CHK("frozen cpl", 1'b1, cpl_valid)
      ce = 1'b1;
      // Bounded drain of outstanding notes
      for (int n = 0; n < 200 && (cq.size() != 0 || eq.size() != 0); n++) @(negedge mclk);
      `CHK("pending notes", 0, cq.size() + eq.size())
      report_and_stop();
   end
endmodule
`default_nettype wire
